// ---- rtl/ct_cfg.svh ----
// Purpose : Offsets, field positions, codes and reset values of the
//           counter/timer block
// Assumes : Included by the design module, the checker and the testbench
// Notes   : Register offsets are word indices on the plain register port
`ifndef CT_CFG_SVH
`define CT_CFG_SVH

// ---------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------
`define CT_ADDR_W         4
`define CT_OFS_PRESET_LO  4'h0
`define CT_OFS_PRESET_HI  4'h1
`define CT_OFS_COUNT_LO   4'h2
`define CT_OFS_COUNT_HI   4'h3
`define CT_OFS_START      4'h4
`define CT_OFS_STOP       4'h5
`define CT_OFS_AUX        4'h6
`define CT_OFS_CLKSEL_A   4'h7
`define CT_OFS_CLKSEL_B   4'h8
`define CT_OFS_CMD_A      4'h9
`define CT_OFS_CMD_B      4'ha
`define CT_OFS_ISR        4'hb
`define CT_OFS_IMR        4'hc

// ---------------------------------------------------------------------
// Fields and codes
// ---------------------------------------------------------------------
`define CT_AUX_TIMER_BIT  6
`define CT_AUX_SRC_HI     5
`define CT_AUX_SRC_LO     4
`define CT_SRC_CORE       2'h0
`define CT_SRC_CORE_DIV   2'h1
`define CT_SRC_PIN        2'h2
`define CT_SRC_PIN_DIV    2'h3
`define CT_ISR_READY_BIT  3
`define CT_CMD_TO_ON      4'ha
`define CT_CMD_TO_OFF     4'hc
`define CT_CLKSEL_CT      4'hd
`define CT_PRESCALE_LAST  4'hf

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define CT_RST_BYTE       8'h00
`define CT_RST_COUNT      16'h0000
`define CT_COUNT_ONE      16'h0001

`endif

// ---- rtl/ct_pkg.sv ----
// Purpose : Types shared by the counter/timer block
// Assumes : ct_cfg.svh holds the numeric constants
// Notes   : Timeout sequencing states only
package ct_pkg;

    // -----------------------------------------------------------------
    // Timeout mode sequencer
    // -----------------------------------------------------------------
    typedef enum logic [1:0]
    {
        TO_HALT,   // Stopped, waiting for a character
        TO_STOP1,  // Character seen, one more count clock
        TO_LOAD,   // Stopped, reload on next count clock
        TO_RUN     // Counting toward expiry
    } to_state_e;

endpackage

// ---- rtl/ct_pin_sync.sv ----
// Purpose : Bring the external count clock pin into core_clk
// Assumes : Pin is asynchronous to core_clk
// Notes   : Emits a one-cycle pulse on each rising edge of the pin
module ct_pin_sync
(
    input  wire logic core_clk,   // Core clock
    input  wire logic arst_n,     // Async reset, active low
    input  wire logic pin_in,     // Raw asynchronous pin
    output logic      rise_pulse  // One cycle per rising pin edge
);

    logic meta_r;   // First synchroniser stage
    logic sync_r;   // Second synchroniser stage
    logic prev_r;   // Delayed copy for edge detection

    // -----------------------------------------------------------------
    // Two-stage synchroniser and edge history
    // -----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end
        else
        begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Edge seen only past the second stage
    assign rise_pulse = sync_r & ~prev_r;

endmodule

// ---- rtl/counter_timer_with_rx_timeout.sv ----
// Purpose : 16-bit counter/timer with receive timeout, shared by two
//           serial channels
// Assumes : rx_load pulses come from receivers on core_clk
// Notes   : Registers on a plain port; read data one cycle after strobe
`include "ct_cfg.svh"
module counter_timer_with_rx_timeout
    import ct_pkg::*;
(
    input  wire logic        core_clk,   // 250 MHz core clock
    input  wire logic        arst_n,     // Async reset, active low
    input  wire logic [3:0]  addr,       // Register index
    input  wire logic [7:0]  wdata,      // Write data
    input  wire logic        wr_stb,     // Write strobe
    input  wire logic        rd_stb,     // Read strobe
    output logic      [7:0]  rdata,      // Read data, cycle after strobe
    input  wire logic        ct_pin,     // External count clock pin
    input  wire logic        rx_load_a,  // Channel a char into queue
    input  wire logic        rx_load_b,  // Channel b char into queue
    output logic             ct_out,     // Counter/timer output
    output logic      [3:0]  ct16x_sel,  // rx a, tx a, rx b, tx b on C/T
    output logic             irq         // Level interrupt
);

    // -----------------------------------------------------------------
    // Declarations
    // -----------------------------------------------------------------
    logic [7:0]  preset_lo_r, preset_lo_nxt;   // count_preset_lower
    logic [7:0]  preset_hi_r, preset_hi_nxt;   // count_preset_upper
    logic [7:0]  aux_r,       aux_nxt;         // aux_control_reg
    logic [7:0]  csel_a_r,    csel_a_nxt;      // clock_select_reg a
    logic [7:0]  csel_b_r,    csel_b_nxt;      // clock_select_reg b
    logic [7:0]  imr_r,       imr_nxt;         // interrupt_mask_reg
    logic        ready_r,     ready_nxt;       // Counter ready flag
    logic        to_a_r,      to_a_nxt;        // Timeout on, channel a
    logic        to_b_r,      to_b_nxt;        // Timeout on, channel b
    logic [15:0] count_r,     count_nxt;       // Counting register
    logic        run_r,       run_nxt;         // Counter mode running
    logic        fired_r,     fired_nxt;       // Zero already reached
    logic        out_r,       out_nxt;         // Output level
    to_state_e   tstate_r,    tstate_nxt;      // Timeout sequencer
    logic [3:0]  pre_core_r,  pre_core_nxt;    // Core /16 prescaler
    logic [3:0]  pre_pin_r,   pre_pin_nxt;     // Pin /16 prescaler
    logic [7:0]  rdata_r,     rdata_nxt;       // Read data register
    logic [7:0]  isr_view;                     // interrupt_status_reg
    logic [15:0] preset;                       // Joined reload value
    logic        pin_rise;                     // Synced pin edge
    logic        tick;                         // Count clock enable
    logic        timeout_on;                   // Either channel in timeout
    logic        char_evt;                     // Restarting character
    logic        do_start;                     // Start command read
    logic        do_stop;                      // Stop command read
    logic        w1c_ready;                    // Software clears ready
    logic        set_ready;                    // Event sets ready
    logic        hw_clr;                       // Hardware clears ready
    logic        to_on_cmd;                    // Timeout-on command

    // -----------------------------------------------------------------
    // External clock pin synchroniser
    // -----------------------------------------------------------------
    ct_pin_sync u_pin_sync
    (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .pin_in     (ct_pin),
        .rise_pulse (pin_rise)
    );

    // Reload value from the two preset bytes
    assign preset     = {preset_hi_r, preset_lo_r};
    assign timeout_on = to_a_r | to_b_r;
    // Either receiver in timeout restarts the count
    assign char_evt   = (rx_load_a & to_a_r) | (rx_load_b & to_b_r);
    // Start and stop are void while timeout is active
    assign do_start   = rd_stb & (addr == `CT_OFS_START) & ~timeout_on;
    assign do_stop    = rd_stb & (addr == `CT_OFS_STOP) & ~timeout_on;
    assign w1c_ready  = wr_stb & (addr == `CT_OFS_ISR)
                      & wdata[`CT_ISR_READY_BIT];
    assign to_on_cmd  = wr_stb & (wdata[7:4] == `CT_CMD_TO_ON)
                      & (addr == `CT_OFS_CMD_A | addr == `CT_OFS_CMD_B);

    // -----------------------------------------------------------------
    // Count clock selection and prescalers
    // -----------------------------------------------------------------
    always_comb
    begin
        pre_core_nxt = pre_core_r + 4'h1;
        pre_pin_nxt  = pin_rise ? pre_pin_r + 4'h1 : pre_pin_r;
        // Source picked by aux bits 5..4
        case (aux_r[`CT_AUX_SRC_HI:`CT_AUX_SRC_LO])
            `CT_SRC_CORE:     tick = 1'b1;
            `CT_SRC_CORE_DIV: tick = (pre_core_r == `CT_PRESCALE_LAST);
            `CT_SRC_PIN:      tick = pin_rise;
            `CT_SRC_PIN_DIV:  tick = pin_rise
                                   & (pre_pin_r == `CT_PRESCALE_LAST);
            default:          tick = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pre_core_r <= 4'h0;
            pre_pin_r  <= 4'h0;
        end
        else
        begin
            pre_core_r <= pre_core_nxt;
            pre_pin_r  <= pre_pin_nxt;
        end
    end

    // -----------------------------------------------------------------
    // Counter core: timer, counter and timeout modes
    // -----------------------------------------------------------------
    always_comb
    begin
        count_nxt  = count_r;
        run_nxt    = run_r;
        fired_nxt  = fired_r;
        out_nxt    = out_r;
        tstate_nxt = tstate_r;
        set_ready  = 1'b0;
        hw_clr     = 1'b0;
        if (timeout_on)
        begin
            // Timeout sequencing driven by the data stream
            case (tstate_r)
                TO_HALT: count_nxt = count_r;
                TO_STOP1:
                begin
                    // One more count clock, then stop
                    if (tick)
                    begin
                        count_nxt  = count_r - `CT_COUNT_ONE;
                        tstate_nxt = TO_LOAD;
                    end
                end
                TO_LOAD:
                begin
                    // Reload and restart on next count clock
                    if (tick)
                    begin
                        count_nxt  = preset;
                        tstate_nxt = TO_RUN;
                    end
                end
                TO_RUN:
                begin
                    if (tick)
                    begin
                        count_nxt = count_r - `CT_COUNT_ONE;
                        // Count ran out before next character
                        if (count_r <= `CT_COUNT_ONE)
                        begin
                            count_nxt  = `CT_RST_COUNT;
                            set_ready  = 1'b1;
                            out_nxt    = 1'b0;
                            tstate_nxt = TO_HALT;
                        end
                    end
                end
                default:
                begin
                    tstate_nxt = TO_HALT;
                end
            endcase
            if (char_evt)
            begin
                // New character withdraws the timeout flag
                hw_clr     = 1'b1;
                out_nxt    = 1'b1;
                tstate_nxt = TO_STOP1;
            end
        end
        else if (aux_r[`CT_AUX_TIMER_BIT])
        begin
            // Timer: toggle every preset count clocks
            if (tick)
            begin
                if (count_r <= `CT_COUNT_ONE)
                begin
                    count_nxt = preset;
                    out_nxt   = ~out_r;
                    // Falling edge flags ready, stop or not
                    set_ready = out_r;
                end
                else
                begin
                    count_nxt = count_r - `CT_COUNT_ONE;
                end
            end
        end
        else
        begin
            // Counter: one-shot countdown while running
            if (run_r && tick)
            begin
                // Wraps through zero to full scale
                count_nxt = count_r - `CT_COUNT_ONE;
                if (count_r == `CT_COUNT_ONE && !fired_r)
                begin
                    // Reaching zero flags and drops the output
                    set_ready = 1'b1;
                    out_nxt   = 1'b0;
                    fired_nxt = 1'b1;
                end
            end
        end
        if (to_on_cmd)
            tstate_nxt = TO_HALT;
        if (do_start)
        begin
            // Start copies the preset into the counter
            count_nxt = preset;
            run_nxt   = 1'b1;
            fired_nxt = 1'b0;
            out_nxt   = 1'b1;
        end
        if (do_stop)
        begin
            // Stop halts counting in counter mode only (timer keeps toggling) and clears ready
            run_nxt = 1'b0;
            hw_clr  = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count_r  <= `CT_RST_COUNT;
            run_r    <= 1'b0;
            fired_r  <= 1'b0;
            out_r    <= 1'b1;
            tstate_r <= TO_HALT;
        end
        else
        begin
            count_r  <= count_nxt;
            run_r    <= run_nxt;
            fired_r  <= fired_nxt;
            out_r    <= out_nxt;
            tstate_r <= tstate_nxt;
        end
    end

    // -----------------------------------------------------------------
    // Register writes, commands and ready flag
    // -----------------------------------------------------------------
    always_comb
    begin
        preset_lo_nxt = preset_lo_r;
        preset_hi_nxt = preset_hi_r;
        aux_nxt       = aux_r;
        csel_a_nxt    = csel_a_r;
        csel_b_nxt    = csel_b_r;
        imr_nxt       = imr_r;
        to_a_nxt      = to_a_r;
        to_b_nxt      = to_b_r;
        ready_nxt     = ready_r;
        if (wr_stb)
        begin
            case (addr)
                `CT_OFS_PRESET_LO: preset_lo_nxt = wdata;
                `CT_OFS_PRESET_HI: preset_hi_nxt = wdata;
                `CT_OFS_AUX:       aux_nxt       = wdata;
                `CT_OFS_CLKSEL_A:  csel_a_nxt    = wdata;
                `CT_OFS_CLKSEL_B:  csel_b_nxt    = wdata;
                `CT_OFS_IMR:       imr_nxt       = wdata;
                // Channel commands enter or leave timeout
                `CT_OFS_CMD_A:
                begin
                    if (wdata[7:4] == `CT_CMD_TO_ON)
                        to_a_nxt = 1'b1;
                    else if (wdata[7:4] == `CT_CMD_TO_OFF)
                        to_a_nxt = 1'b0;
                end
                `CT_OFS_CMD_B:
                begin
                    if (wdata[7:4] == `CT_CMD_TO_ON)
                        to_b_nxt = 1'b1;
                    else if (wdata[7:4] == `CT_CMD_TO_OFF)
                        to_b_nxt = 1'b0;
                end
                default:           imr_nxt       = imr_r;
            endcase
        end
        // Clears first, an event in the same cycle wins
        if (hw_clr || w1c_ready)
            ready_nxt = 1'b0;
        if (to_on_cmd)
            ready_nxt = 1'b0;
        if (set_ready)
            ready_nxt = 1'b1;
    end

    // Register bank, timeout enables and ready flag
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            preset_lo_r <= `CT_RST_BYTE;
            preset_hi_r <= `CT_RST_BYTE;
            aux_r       <= `CT_RST_BYTE;
            csel_a_r    <= `CT_RST_BYTE;
            csel_b_r    <= `CT_RST_BYTE;
            imr_r       <= `CT_RST_BYTE;
            to_a_r      <= 1'b0;
            to_b_r      <= 1'b0;
            ready_r     <= 1'b0;
        end
        else
        begin
            preset_lo_r <= preset_lo_nxt;
            preset_hi_r <= preset_hi_nxt;
            aux_r       <= aux_nxt;
            csel_a_r    <= csel_a_nxt;
            csel_b_r    <= csel_b_nxt;
            imr_r       <= imr_nxt;
            to_a_r      <= to_a_nxt;
            to_b_r      <= to_b_nxt;
            ready_r     <= ready_nxt;
        end
    end

    // -----------------------------------------------------------------
    // Status view, interrupt and read data
    // -----------------------------------------------------------------
    // Only the ready bit lives here; all else reads zero
    always_comb
    begin
        isr_view = `CT_RST_BYTE;
        isr_view[`CT_ISR_READY_BIT] = ready_r;
    end

    // Masked ready drives the level interrupt
    assign irq = |(isr_view & imr_r);

    always_comb
    begin
        rdata_nxt = `CT_RST_BYTE;
        if (rd_stb)
        begin
            case (addr)
                `CT_OFS_PRESET_LO: rdata_nxt = preset_lo_r;
                `CT_OFS_PRESET_HI: rdata_nxt = preset_hi_r;
                // Live counter value
                `CT_OFS_COUNT_LO:  rdata_nxt = count_r[7:0];
                `CT_OFS_COUNT_HI:  rdata_nxt = count_r[15:8];
                `CT_OFS_AUX:       rdata_nxt = aux_r;
                `CT_OFS_CLKSEL_A:  rdata_nxt = csel_a_r;
                `CT_OFS_CLKSEL_B:  rdata_nxt = csel_b_r;
                `CT_OFS_ISR:       rdata_nxt = isr_view;
                `CT_OFS_IMR:       rdata_nxt = imr_r;
                default:           rdata_nxt = `CT_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata_r <= `CT_RST_BYTE;
        else
            rdata_r <= rdata_nxt;
    end

    assign rdata  = rdata_r;
    assign ct_out = out_r;

    // -----------------------------------------------------------------
    // 16x sampling for each receiver/transmitter fed by the C/T
    // -----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_sel
            logic [7:0] csel;   // Clock select byte of this channel
            logic [3:0] field;  // Receive (even) or transmit (odd) half
            assign csel  = (gi < 2) ? csel_a_r : csel_b_r;
            assign field = (gi % 2 == 0) ? csel[7:4] : csel[3:0];
            assign ct16x_sel[gi] = (field == `CT_CLKSEL_CT);
        end
    endgenerate

endmodule

// ---- verif/ct_checker_assertions.sv ----
// Purpose : Port-level checks of the counter/timer block
// Assumes : One core_clk domain, arst_n asynchronous and active low
// Notes   : Shadows the mask bit and timeout commands from the write port
`include "ct_cfg.svh"
module ct_checker
    import ct_pkg::*;
(
    input wire logic       core_clk,  // Core clock
    input wire logic       arst_n,    // Async reset, active low
    input wire logic [3:0] addr,      // Register index
    input wire logic [7:0] wdata,     // Write data
    input wire logic       wr_stb,    // Write strobe
    input wire logic       rd_stb,    // Read strobe
    input wire logic [7:0] rdata,     // Read data
    input wire logic       ct_pin,    // External count clock pin
    input wire logic       rx_load_a, // Channel a load
    input wire logic       rx_load_b, // Channel b load
    input wire logic       ct_out,    // Counter/timer output
    input wire logic [3:0] ct16x_sel, // 16x unit selects
    input wire logic       irq        // Level interrupt
);
    logic mask_r;                     // Shadow of mask bit 3
    logic to_a_r;                     // Channel a in timeout
    logic to_b_r;                     // Channel b in timeout
    logic to_on;                      // Either channel in timeout
    logic stop_c;                     // Stop command this cycle
    logic sel_rx;                     // Clock select rx field is C/T
    logic sel_tx;                     // Clock select tx field is C/T
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    assign to_on  = to_a_r | to_b_r;
    assign stop_c = rd_stb && addr == `CT_OFS_STOP;
    assign sel_rx = wdata[7:4] == `CT_CLKSEL_CT;
    assign sel_tx = wdata[3:0] == `CT_CLKSEL_CT;
    // Shadow state follows the host writes
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mask_r <= 1'b0;
            to_a_r <= 1'b0;
            to_b_r <= 1'b0;
        end
        else if (wr_stb)
        begin
            if (addr == `CT_OFS_IMR)
                mask_r <= wdata[`CT_ISR_READY_BIT];
            if (addr == `CT_OFS_CMD_A && wdata[7:4] == `CT_CMD_TO_ON)
                to_a_r <= 1'b1;
            if (addr == `CT_OFS_CMD_A && wdata[7:4] == `CT_CMD_TO_OFF)
                to_a_r <= 1'b0;
            if (addr == `CT_OFS_CMD_B && wdata[7:4] == `CT_CMD_TO_ON)
                to_b_r <= 1'b1;
            if (addr == `CT_OFS_CMD_B && wdata[7:4] == `CT_CMD_TO_OFF)
                to_b_r <= 1'b0;
        end
    end
    // Read data is zero outside the cycle after a read
    rd_idle_a: assert property (!$past(rd_stb) |-> rdata == 8'h00)
        else $error("read data not zero when idle");
    // A falling output sets ready, seen at once when unmasked
    fall_irq_a: assert property ($fell(ct_out) && mask_r |-> irq)
        else $error("output fall without interrupt");
    stop_clr_a: assert property (stop_c && !to_on
        |=> !irq || $fell(ct_out))
        else $error("stop left ready set");
    w1c_clr_a: assert property (wr_stb && addr == `CT_OFS_ISR && wdata[3]
        |=> !irq || $fell(ct_out))
        else $error("status write one did not clear");
    rise_why_a: assert property ($rose(irq)
        |-> $fell(ct_out) || $past(wr_stb))
        else $error("interrupt rose without cause");
    char_clr_a: assert property (to_a_r && rx_load_a
        || to_b_r && rx_load_b |=> ct_out && !irq)
        else $error("character did not clear ready");
    sel_16x_a: assert property (wr_stb && addr == `CT_OFS_CLKSEL_A
        |=> ct16x_sel[1:0] == {$past(sel_tx), $past(sel_rx)})
        else $error("16x select wrong");
    to_on_a: assert property (wr_stb && wdata[7:4] == `CT_CMD_TO_ON
        && (addr == `CT_OFS_CMD_A || addr == `CT_OFS_CMD_B) |=> !irq)
        else $error("timeout on left ready set");
    stop_ign_a: assert property (to_on && stop_c && irq && !rx_load_a
        && !rx_load_b |=> irq)
        else $error("stop acted in timeout mode");
    cover property ($fell(ct_out) && mask_r);
    cover property (stop_c && to_on);
    cover property (to_b_r && rx_load_b);
endmodule
bind counter_timer_with_rx_timeout ct_checker i_ct_checker (.core_clk,
    .arst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .ct_pin, .rx_load_a,
    .rx_load_b, .ct_out, .ct16x_sel, .irq);

// ---- verif/rx_feed.sv ----
// Purpose : Stands in for the two receivers loading their queues
// Assumes : send is called at or just after a rising core_clk edge
// Notes   : Each load pulse lasts one core_clk cycle
module rx_feed
(
    input  wire logic core_clk,  // Core clock
    output logic      rx_load_a, // Channel a load pulse
    output logic      rx_load_b  // Channel b load pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle at time zero
    initial
    begin
        rx_load_a = 1'b0;
        rx_load_b = 1'b0;
    end
    // One character on the chosen channels, both at once allowed
    task automatic send(input logic ca, input logic cb);
        rx_load_a <= ca;
        rx_load_b <= cb;
        @(posedge core_clk);
        rx_load_a <= 1'b0;
        rx_load_b <= 1'b0;
        #1;
    endtask
endmodule

// ---- verif/tb_top.sv ----
// Purpose : Self-checking bench of the counter/timer block
// Assumes : Count source is the core clock, one tick a cycle, except the final counter run clocked from the pin
// Notes   : Bus strobes change just after rising edges
`include "ct_cfg.svh"
module tb_top
    import ct_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       core_clk, arst_n, wr_stb, rd_stb, ct_pin, ct_out, irq;
    logic       rx_load_a, rx_load_b;
    logic [3:0] addr, ct16x_sel;
    logic [7:0] wdata, rdata, d;
    int         error_cnt, checks, cyc, n;
    counter_timer_with_rx_timeout i_counter_timer_with_rx_timeout (.core_clk,
        .arst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .ct_pin,
        .rx_load_a, .rx_load_b, .ct_out, .ct16x_sel, .irq);
    rx_feed i_rx_feed (.core_clk, .rx_load_a, .rx_load_b);
    // 250 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // Count pin, edges kept off core_clk rising edges
    always #8 ct_pin = ~ct_pin;
    // Hang guard
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        addr <= a;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        #1 v = rdata;
    endtask
    // Read and compare in one call
    task automatic rc(input logic [3:0] a, input logic [7:0] e);
        rd(a, d);
        chk(d, e);
    endtask
    // Cycles until irq, bounded
    task automatic wait_irq(output int k);
        k = 0;
        while (irq !== 1'b1 && k < 400)
        begin
            @(posedge core_clk);
            #1 k++;
        end
    endtask
    // Cycles until the output changes, bounded
    task automatic wait_out(output int k);
        logic v;
        k = 0;
        v = ct_out;
        while (ct_out === v && k < 100)
        begin
            @(posedge core_clk);
            #1 k++;
        end
    endtask
    task automatic end_of_test();
        $display("TB: errors=%0d checks=%0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        {arst_n, addr, wdata, wr_stb, rd_stb, ct_pin} = '0;
        {error_cnt, checks, cyc} = '0;
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        rc(`CT_OFS_ISR, 8'h00);
        chk(8'({ct_out, irq, ct16x_sel}), 8'h20);
        wr(`CT_OFS_CLKSEL_A, 8'hdd);
        wr(`CT_OFS_CLKSEL_B, 8'hd0);
        chk(8'(ct16x_sel), 8'h07);
        wr(4'hf, 8'hff);
        rc(4'hf, 8'h00);
        // Counter mode one-shot and wrap
        wr(`CT_OFS_IMR, 8'h08);
        wr(`CT_OFS_PRESET_LO, 8'h05);
        wr(`CT_OFS_PRESET_HI, 8'h01);
        rc(`CT_OFS_PRESET_HI, 8'h01);
        wr(`CT_OFS_AUX, 8'h00);
        rd(`CT_OFS_START, d);
        rc(`CT_OFS_COUNT_HI, 8'h01);
        wait_irq(n);
        chk(8'({irq, ct_out}), 8'h02);
        rc(`CT_OFS_ISR, 8'h08);
        repeat (10) @(posedge core_clk);
        rc(`CT_OFS_COUNT_HI, 8'hff);
        wr(`CT_OFS_ISR, 8'h08);
        repeat (20) @(posedge core_clk);
        rc(`CT_OFS_ISR, 8'h00);
        chk(8'(ct_out), 8'h00);
        rd(`CT_OFS_STOP, d);
        // Timer mode square wave, ready after stop
        wr(`CT_OFS_PRESET_HI, 8'h00);
        wr(`CT_OFS_PRESET_LO, 8'h03);
        wr(`CT_OFS_AUX, 8'h40);
        rd(`CT_OFS_START, d);
        wait_out(n);
        wait_out(n);
        chk(8'(n), 8'h03);
        rd(`CT_OFS_STOP, d);
        wait_irq(n);
        chk(8'(irq), 8'h01);
        rd(`CT_OFS_STOP, d);
        chk(8'(irq), 8'h00);
        // Timeout mode
        wr(`CT_OFS_AUX, 8'h00);
        wr(`CT_OFS_PRESET_LO, 8'h0a);
        rd(`CT_OFS_START, d);
        wr(`CT_OFS_CMD_A, 8'ha0);
        repeat (30) @(posedge core_clk);
        chk(8'(irq), 8'h00);
        rd(`CT_OFS_START, d);
        repeat (30) @(posedge core_clk);
        chk(8'(irq), 8'h00);
        i_rx_feed.send(1'b1, 1'b0);
        wait_irq(n);
        chk(8'(n), 8'h0c);
        rc(`CT_OFS_ISR, 8'h08);
        rd(`CT_OFS_STOP, d);
        chk(8'(irq), 8'h01);
        i_rx_feed.send(1'b1, 1'b0);
        chk(8'({irq, ct_out}), 8'h01);
        rc(`CT_OFS_ISR, 8'h00);
        wait_irq(n);
        wr(`CT_OFS_CMD_B, 8'ha0);
        repeat (6)
        begin
            i_rx_feed.send(1'b0, 1'b1);
            repeat (6) @(posedge core_clk);
        end
        chk(8'(irq), 8'h00);
        wait_irq(n);
        chk(8'(irq), 8'h01);
        wr(`CT_OFS_CMD_A, 8'hc0);
        wr(`CT_OFS_CMD_B, 8'hc0);
        wr(`CT_OFS_ISR, 8'h08);
        wr(`CT_OFS_AUX, 8'h20);
        rd(`CT_OFS_START, d);
        wait_irq(n);
        chk(8'(irq), 8'h01);
        chk(8'(n > 32), 8'h01);
        end_of_test();
    end
endmodule
